//--- common/idle_pkg.sv
// Constants, register map and timing for the idle/sleep/wake sequencer
// Behaviour
// - Internal idle: CPU stopped, peripherals on internal clock
// - Internal run plus idle enable enters internal idle
// - Select-high plus idle enable enters internal idle
// - Switch to internal clock stops primary, clears ready
// - Internal idle wake: peripherals kept, CPU after delay
// - Wake leaves idle enable and clock select unchanged
// - Watchdog or clock monitor keep internal oscillator on
// - Only interrupt, reset or watchdog end low power
// - Enabled interrupt flag starts exit at once
// - Branch to vector only when global enable set
// - Fixed CPU wake delay, then resume execution
// - Watchdog wakes when asleep, resets when running
// - Reset held by start-up timer until primary ready
// - Fast start runs internal clock until primary ready
// - No start-up timer from primary idle, non-crystal
// - Crystal exit waits start-up, PLL adds lock time
// - CPU wake delay overlaps others; alone for external
// - Wake onto internal clock executes during settling
// - Internal source is the slow internal RC clock
// - PLL modes wait lock time after start-up period
// - Sleep without idle enable stops the primary oscillator
// - Watchdog wake goes to currently selected run mode
package idle_pkg;
    localparam int AW = 4;
    localparam int DW = 32;
    localparam int CW = 32;
    localparam int IRQ_N = 8;

    localparam logic [AW-1:0] CTRL_OFS = 4'h0;
    localparam logic [AW-1:0] IRQCTL_OFS = 4'h4;
    localparam logic [AW-1:0] IRQEN_OFS = 4'h8;
    localparam logic [AW-1:0] STATUS_OFS = 4'hc;

    localparam int IDLE_EN_BIT = 0;
    localparam int SEL_LO_BIT = 1;
    localparam int SEL_HI_BIT = 2;
    localparam int WDT_EN_BIT = 3;
    localparam int FSCM_EN_BIT = 4;
    localparam int TWO_SPEED_BIT = 5;
    localparam int PRI_MODE_LSB = 6;
    localparam int GIE_BIT = 7;
    localparam int ST_READY_BIT = 0;
    localparam int ST_CPU_BIT = 1;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_SETTLE_BIT = 5;

    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [7:0] IRQCTL_RST = 8'h00;
    localparam logic [IRQ_N-1:0] IRQEN_RST = 8'h00;

    // Primary oscillator modes
    localparam logic [2:0] PM_CRYSTAL = 3'h0;
    localparam logic [2:0] PM_FAST_CRYSTAL = 3'h1;
    localparam logic [2:0] PM_CRYSTAL_PLL = 3'h2;
    localparam logic [2:0] PM_FAST_CRYSTAL_PLL = 3'h3;
    localparam logic [2:0] PM_EXT_CLOCK = 3'h4;
    localparam logic [2:0] PM_INT = 3'h5;

    typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} clk_src_e;
    typedef enum logic [2:0] {ST_RSTHOLD, ST_RUN, ST_IDLE, ST_SLEEP, ST_WAKE} pm_state_e;

    localparam int CLK_PERIOD_NS = 4;
    localparam int CSD_NS = 2000;
    localparam int STARTUP_NS = 65536;
    localparam int PLL_NS = 2000000;
    localparam int SETTLE_NS = 1000;
    localparam int CSD_CYC = (CSD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PLL_CYC = (PLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- rtl/idle_sleep_wake_control.sv
// Power-managed mode sequencer with a classic Wishbone register slave
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module idle_sleep_wake_control
#(
    parameter int unsigned STARTUP_CYCLES = idle_pkg::STARTUP_CYC,
    parameter int unsigned PLL_CYCLES = idle_pkg::PLL_CYC,
    parameter int unsigned CSD_CYCLES = idle_pkg::CSD_CYC,
    parameter int unsigned SETTLE_CYCLES = idle_pkg::SETTLE_CYC
)
(
    input logic ref_clk,
    input logic rst_b,
    input logic ce,
    input logic cyc_i,
    input logic stb_i,
    input logic we_i,
    input logic [idle_pkg::AW-1:0] adr_i,
    input logic [3:0] sel_i,
    input logic [idle_pkg::DW-1:0] dat_i,
    output logic [idle_pkg::DW-1:0] dat_o,
    output logic ack_o,
    input logic sleepExec,
    input logic [idle_pkg::IRQ_N-1:0] irqFlags,
    input logic wdtTimeout,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic [1:0] clkSrc,
    output logic primaryOscEn,
    output logic intRcEn,
    output logic wdtReset,
    output logic irqBranch,
    output logic intRcSettling
);
    import idle_pkg::*;

    pm_state_e state_reg;
    pm_state_e state_next;
    clk_src_e idleSrc_reg;
    clk_src_e clkSrc_reg;
    clk_src_e clkSrc_next;
    logic [8:0] ctrl_reg;
    logic [7:0] irqCtl_reg;
    logic [IRQ_N-1:0] irqEn_reg;
    logic [CW-1:0] priCnt_reg;
    logic [CW-1:0] csdCnt_reg;
    logic [CW-1:0] settleCnt_reg;
    logic priReady_reg;
    logic wasIdle_reg;
    logic irqWake_reg;
    logic ack_reg;
    logic [DW-1:0] dat_reg;
    logic cpuClkEn_reg;
    logic periphClkEn_reg;
    logic primaryOscEn_reg;
    logic primaryOscEn_next;
    logic intRcEn_reg;
    logic wdtReset_reg;
    logic irqBranch_reg;

    // Bus decode
    wire busReq = cyc_i && stb_i && !ack_reg;
    // Write lands on the edge at which the master sees ack
    wire busWr = cyc_i && stb_i && we_i && ack_reg;
    wire hitCtrl = adr_i == CTRL_OFS;
    wire hitIrqCtl = adr_i == IRQCTL_OFS;
    wire hitIrqEn = adr_i == IRQEN_OFS;
    wire hitStatus = adr_i == STATUS_OFS;
    wire [DW-1:0] wMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [DW-1:0] ctrlW = ({23'h0, ctrl_reg} & ~wMask) | (dat_i & wMask);
    wire [DW-1:0] irqCtlW = ({24'h0, irqCtl_reg} & ~wMask) | (dat_i & wMask);
    wire [DW-1:0] irqEnW = ({{(DW-IRQ_N){1'b0}}, irqEn_reg} & ~wMask) | (dat_i & wMask);
    wire [DW-1:0] statusWord = {26'h0, (settleCnt_reg != '0), state_reg, cpuClkEn_reg, priReady_reg};
    wire [DW-1:0] rdData = hitCtrl ? {23'h0, ctrl_reg} :
                           hitIrqCtl ? {24'h0, irqCtl_reg} :
                           hitIrqEn ? {{(DW-IRQ_N){1'b0}}, irqEn_reg} :
                           hitStatus ? statusWord : 32'h0000_0000;

    // Control field decode
    wire idleOnSleep = ctrl_reg[IDLE_EN_BIT];
    wire selHi = ctrl_reg[SEL_HI_BIT];
    wire selLo = ctrl_reg[SEL_LO_BIT];
    wire wdtEn = ctrl_reg[WDT_EN_BIT];
    wire fscmEn = ctrl_reg[FSCM_EN_BIT];
    wire fastStart = ctrl_reg[TWO_SPEED_BIT] || fscmEn;
    wire [2:0] priMode = ctrl_reg[PRI_MODE_LSB +: 3];
    wire globalIrqEn = irqCtl_reg[GIE_BIT];
    // Select-low ignored once select-high is set
    wire clk_src_e selSrc = selHi ? SRC_INT : (selLo ? SRC_SEC : SRC_PRI);
    // Only crystal modes need the start-up timer
    wire needsStartup = (priMode == PM_CRYSTAL) || (priMode == PM_FAST_CRYSTAL) ||
                        (priMode == PM_CRYSTAL_PLL) || (priMode == PM_FAST_CRYSTAL_PLL);
    wire needsPll = (priMode == PM_CRYSTAL_PLL) || (priMode == PM_FAST_CRYSTAL_PLL);
    wire [CW-1:0] priTarget = (needsStartup ? CW'(STARTUP_CYCLES) : '0) +
                              (needsPll ? CW'(PLL_CYCLES) : '0);
    wire clk_src_e runSrc = (selSrc == SRC_PRI && !priReady_reg) ? SRC_INT : selSrc;

    // Wake decode
    wire asleep = (state_reg == ST_IDLE) || (state_reg == ST_SLEEP);
    wire irqPend = |(irqFlags & irqEn_reg);
    wire wakeEvt = irqPend || wdtTimeout;
    wire csdDone = csdCnt_reg == '0;
    // Concurrent delays: CPU delay must end, and the oscillator wait too unless fast start is on
    wire wakeOk = csdDone && (selSrc != SRC_PRI || priReady_reg || fastStart);
    wire toRun = (state_reg == ST_WAKE) && wakeOk;
    // Settling only on entry from sleep or the secondary source
    wire startSettle = toRun && runSrc == SRC_INT &&
                       (!wasIdle_reg || idleSrc_reg == SRC_SEC);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RSTHOLD:
            begin
                if (fastStart || priReady_reg)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (sleepExec)
                begin
                    state_next = idleOnSleep ? ST_IDLE : ST_SLEEP;
                end
            end
            ST_IDLE, ST_SLEEP:
            begin
                if (wakeEvt)
                begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if (wakeOk)
                begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    wire clk_src_e idleSrc_next = (state_reg == ST_RUN && sleepExec && idleOnSleep) ? selSrc : idleSrc_reg;

    always_comb
    begin
        clkSrc_next = clkSrc_reg;
        primaryOscEn_next = 1'b0;
        unique case (state_next)
            ST_RSTHOLD:
            begin
                clkSrc_next = SRC_INT;
                primaryOscEn_next = 1'b1;
            end
            ST_RUN:
            begin
                clkSrc_next = runSrc;
                primaryOscEn_next = selSrc == SRC_PRI;
            end
            ST_IDLE:
            begin
                clkSrc_next = idleSrc_next;
                primaryOscEn_next = idleSrc_next == SRC_PRI;
            end
            ST_SLEEP:
            begin
                primaryOscEn_next = 1'b0;
            end
            ST_WAKE:
            begin
                clkSrc_next = idleSrc_reg;
                primaryOscEn_next = selSrc == SRC_PRI;
            end
        endcase
    end

    wire cpuClk_next = state_next == ST_RUN;
    wire periph_next = (state_next == ST_RUN) || (state_next == ST_IDLE) ||
                       (state_next == ST_WAKE && (state_reg == ST_IDLE || wasIdle_reg));
    // The 31 kHz internal RC clock is the only internal source
    wire internal_rc_clock_next = wdtEn || fscmEn || clkSrc_next == SRC_INT ||
                      (state_next == ST_WAKE && selSrc == SRC_INT);

    // Bus slave and registers; the sequencer never writes config
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
            ctrl_reg <= CTRL_RST;
            irqCtl_reg <= IRQCTL_RST;
            irqEn_reg <= IRQEN_RST;
        end
        else if (ce)
        begin
            ack_reg <= busReq;
            dat_reg <= busReq ? rdData : '0;
            if (busWr && hitCtrl)
            begin
                ctrl_reg <= ctrlW[8:0];
            end
            if (busWr && hitIrqCtl)
            begin
                irqCtl_reg <= irqCtlW[7:0];
            end
            if (busWr && hitIrqEn)
            begin
                irqEn_reg <= irqEnW[IRQ_N-1:0];
            end
        end
    end

    // Primary oscillator start-up timer and lock wait
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            priCnt_reg <= '0;
            priReady_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (!primaryOscEn_reg)
            begin
                priCnt_reg <= '0;
                priReady_reg <= 1'b0;
            end
            else if (!priReady_reg)
            begin
                if (priCnt_reg >= priTarget)
                begin
                    priReady_reg <= 1'b1;
                end
                else
                begin
                    priCnt_reg <= priCnt_reg + 1'b1;
                end
            end
        end
    end

    // Mode state and wake bookkeeping
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_RSTHOLD;
            idleSrc_reg <= SRC_PRI;
            csdCnt_reg <= '0;
            wasIdle_reg <= 1'b0;
            irqWake_reg <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            idleSrc_reg <= idleSrc_next;
            if (asleep && wakeEvt)
            begin
                csdCnt_reg <= CW'(CSD_CYCLES) - 1'b1;
                wasIdle_reg <= state_reg == ST_IDLE;
                irqWake_reg <= irqPend;
            end
            else if (!csdDone)
            begin
                csdCnt_reg <= csdCnt_reg - 1'b1;
            end
        end
    end

    // Output flops follow the next state so they align with state_reg
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            clkSrc_reg <= SRC_INT;
            cpuClkEn_reg <= 1'b0;
            periphClkEn_reg <= 1'b0;
            primaryOscEn_reg <= 1'b1;
            intRcEn_reg <= 1'b1;
            wdtReset_reg <= 1'b0;
            irqBranch_reg <= 1'b0;
            settleCnt_reg <= '0;
        end
        else if (ce)
        begin
            clkSrc_reg <= clkSrc_next;
            cpuClkEn_reg <= cpuClk_next;
            periphClkEn_reg <= periph_next;
            primaryOscEn_reg <= primaryOscEn_next;
            intRcEn_reg <= internal_rc_clock_next;
            wdtReset_reg <= state_reg == ST_RUN && wdtTimeout;
            irqBranch_reg <= toRun && irqWake_reg && globalIrqEn;
            if (startSettle)
            begin
                settleCnt_reg <= CW'(SETTLE_CYCLES);
            end
            else if (settleCnt_reg != '0)
            begin
                settleCnt_reg <= settleCnt_reg - 1'b1;
            end
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;
    assign cpuClkEn = cpuClkEn_reg;
    assign periphClkEn = periphClkEn_reg;
    assign clkSrc = clkSrc_reg;
    assign primaryOscEn = primaryOscEn_reg;
    assign intRcEn = intRcEn_reg;
    assign wdtReset = wdtReset_reg;
    assign irqBranch = irqBranch_reg;
    assign intRcSettling = settleCnt_reg != '0;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    sequence sleepCmd;
        ce && state_reg == ST_RUN && sleepExec;
    endsequence

    a_idle_cpu_stop: assert property (state_reg == ST_IDLE && idleSrc_reg == SRC_INT
        |-> !cpuClkEn_reg && periphClkEn_reg && clkSrc_reg == SRC_INT)
        else $error("internal idle clocks wrong");
    a_idle_entry: assert property (sleepCmd and (idleOnSleep && selHi)
        |=> state_reg == ST_IDLE && idleSrc_reg == SRC_INT)
        else $error("idle entry missed");
    a_sleep_entry: assert property (sleepCmd and !idleOnSleep |=> state_reg == ST_SLEEP
        ##0 !primaryOscEn_reg)
        else $error("sleep entry missed");
    a_rc_pri_off: assert property (ce && clkSrc_next == SRC_INT && state_next == ST_IDLE
        |=> !primaryOscEn_reg and (ce |=> !priReady_reg))
        else $error("primary not stopped");
    a_internal_rc_clock_kept: assert property (ce && (wdtEn || fscmEn) |=> intRcEn_reg)
        else $error("internal oscillator stopped");
    a_exit_cause: assert property (ce && asleep && !wakeEvt |=> state_reg != ST_WAKE)
        else $error("wake without cause");
    a_irq_wake: assert property (ce && asleep && irqPend |=> state_reg == ST_WAKE)
        else $error("interrupt wake missed");
    a_branch_gie: assert property (irqBranch_reg |-> $past(globalIrqEn) && cpuClkEn_reg)
        else $error("branch without global enable");
    a_wake_delay: assert property (ce && asleep && wakeEvt
        |=> !cpuClkEn_reg [*2])
        else $error("CPU resumed too early");
    a_delay_done: assert property ($fell(state_reg == ST_WAKE) && state_reg == ST_RUN
        |-> $past(csdDone))
        else $error("wake delay cut short");
    a_wdt_run: assert property (ce && state_reg == ST_RUN && wdtTimeout |=> wdtReset_reg)
        else $error("watchdog reset missed");
    a_cfg_kept: assert property (ce && !(busWr && hitCtrl) |=> $stable(ctrl_reg))
        else $error("config changed by wake");
    a_reset_hold: assert property (state_reg == ST_RSTHOLD && !fastStart
        |-> !cpuClkEn_reg)
        else $error("CPU ran during reset hold");

    // Settling overlaps execution rather than stalling it
    a_settle_run: assert property (ce && startSettle |=> intRcSettling && cpuClkEn_reg)
        else $error("settling stalled the CPU");
    a_branch_taken: assert property (ce && toRun && irqWake_reg && globalIrqEn |=> irqBranch_reg)
        else $error("vector branch missed");
    a_wake_src: assert property (ce && toRun |=> clkSrc_reg == $past(runSrc))
        else $error("wake to wrong run source");
    a_wake_periph: assert property (state_reg == ST_WAKE && wasIdle_reg |-> periphClkEn_reg)
        else $error("peripheral clock lost on idle wake");
    // Ready flag timing for each primary mode
    a_pll_wait: assert property ($rose(priReady_reg) |-> $past(priCnt_reg) >= $past(priTarget))
        else $error("primary ready before lock wait");
    a_skip_startup: assert property (ce && !needsStartup && primaryOscEn_reg && !priReady_reg |=> priReady_reg)
        else $error("start-up wait not skipped");
    a_ready_drop: assert property (ce && !primaryOscEn_reg |=> !priReady_reg)
        else $error("ready flag kept with primary off");
endmodule

//--- tb/wake_source_model.sv
// Stand-in for the CPU and the wake sources on the sequencer's far side
`timescale 1ns/100ps
module wake_source_model
(
    input wire logic ref_clk,
    input wire logic cpuClkEn,
    input wire logic reqSleep,
    input wire logic [7:0] reqFlags,
    input wire logic reqWdt,
    output logic sleepExec = 1'b0,
    output logic [7:0] irqFlags = 8'h00,
    output logic wdtTimeout = 1'b0
);
    // A halted CPU cannot execute a sleep instruction
    always @(posedge ref_clk)
    begin
        sleepExec <= reqSleep & cpuClkEn;
        irqFlags <= reqFlags;
        wdtTimeout <= reqWdt;
    end
endmodule

//--- tb/idle_sleep_wake_control_bench.sv
// Self-checking bench for the idle/sleep/wake sequencer
`timescale 1ns/100ps
module idle_sleep_wake_control_bench;
    import idle_pkg::*;
    localparam int SUT = 8;
    localparam int PLL = 8;
    localparam int CSD = 4;
    typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] e;} reg_row_s;
    typedef struct {logic [2:0] m; logic g; int lo;} wake_row_s;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack, sleepExec, wdtTimeout, cpuClkEn, periphClkEn, drop;
    logic primaryOscEn, intRcEn, wdtReset, irqBranch, intRcSettling;
    logic [7:0] irqFlags;
    logic [1:0] clkSrc;
    logic reqSleep = 1'b0;
    logic ceIn = 1'b1;
    logic reqWdt = 1'b0;
    logic sawWdt = 1'b0;
    logic sawBr = 1'b0;
    logic [7:0] reqFlags = 8'h00;
    int n_mismatch = 0;
    int comparisons = 0;
    int n;
    // Status first: the later rows disturb the clock state
    reg_row_s regRows [5] = '{'{STATUS_OFS, 32'hffffffff, 32'h00000007},
        '{CTRL_OFS, 32'h00000039, 32'h00000039}, '{IRQCTL_OFS, 32'h00000080, 32'h00000080},
        '{IRQEN_OFS, 32'h000000a5, 32'h000000a5}, '{4'h2, 32'h000000ff, 32'h00000000}};
    wake_row_s wakeRows [5] = '{'{PM_CRYSTAL, 1'b1, SUT}, '{PM_FAST_CRYSTAL, 1'b0, SUT},
        '{PM_CRYSTAL_PLL, 1'b1, SUT + PLL}, '{PM_FAST_CRYSTAL_PLL, 1'b0, SUT + PLL}, '{PM_EXT_CLOCK, 1'b1, CSD}};

    idle_sleep_wake_control #(
        .STARTUP_CYCLES(SUT),
        .PLL_CYCLES(PLL),
        .CSD_CYCLES(CSD),
        .SETTLE_CYCLES(4)
    ) u_idle_sleep_wake_control (
        .ref_clk(ref_clk), .rst_b(rst_b), .ce(ceIn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .sleepExec(sleepExec),
        .irqFlags(irqFlags), .wdtTimeout(wdtTimeout), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
        .clkSrc(clkSrc), .primaryOscEn(primaryOscEn), .intRcEn(intRcEn), .wdtReset(wdtReset),
        .irqBranch(irqBranch), .intRcSettling(intRcSettling));

    wake_source_model u_wake_source_model (
        .ref_clk(ref_clk), .cpuClkEn(cpuClkEn), .reqSleep(reqSleep), .reqFlags(reqFlags),
        .reqWdt(reqWdt), .sleepExec(sleepExec), .irqFlags(irqFlags), .wdtTimeout(wdtTimeout));

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Pulses are one cycle wide, so latch them
    always @(posedge ref_clk)
    begin
        if (wdtReset === 1'b1) sawWdt <= 1'b1;
        if (irqBranch === 1'b1) sawBr <= 1'b1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic chkIn(input int v, input int lo, input int hi, input string m);
        comparisons++;
        if (v < lo || v > hi)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s took %0d cycles, not %0d..%0d", $time, m, v, lo, hi);
        end
    endtask

    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge ref_clk);
            t++;
        end
        while (ack !== 1'b1 && t < 50);
        q = rdat;
        chkIn(t, 1, 49, "bus answer");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic waitCpu();
        n = 0;
        drop = 1'b0;
        while (cpuClkEn !== 1'b1 && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
            if (periphClkEn !== 1'b1) drop = 1'b1;
        end
    endtask

    task automatic sleepNow();
        reqSleep <= 1'b1;
        @(posedge ref_clk);
        reqSleep <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic doReset();
        rst_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk(32'({cpuClkEn, periphClkEn, clkSrc, primaryOscEn, intRcEn}), 32'h0b, "reset outputs");
        waitCpu();
        chkIn(n, SUT + 1, SUT + 5, "start-up hold");
        wb(CTRL_OFS, 1'b0, 32'h0);
        chk(q, 32'h0, "control after reset");
        $display("reset test done");
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        doReset();
        foreach (regRows[i])
        begin
            wb(regRows[i].a, 1'b1, regRows[i].w);
            wb(regRows[i].a, 1'b0, 32'h0);
            chk(q, regRows[i].e, "register readback");
        end
        $display("register rows done");
        foreach (wakeRows[i])
        begin
            wb(CTRL_OFS, 1'b1, 32'(wakeRows[i].m) << 6);
            wb(IRQCTL_OFS, 1'b1, {24'h0, wakeRows[i].g, 7'h0});
            repeat (40) @(posedge ref_clk);
            sleepNow();
            chk(32'({periphClkEn, primaryOscEn}), 32'h0, "sleep clocks");
            sawBr <= 1'b0;
            reqFlags <= 8'h01;
            waitCpu();
            reqFlags <= 8'h00;
            @(posedge ref_clk);
            chkIn(n, wakeRows[i].lo + 3, wakeRows[i].lo + 6, "exit delay");
            chk(32'(sawBr), 32'(wakeRows[i].g), "vector branch");
        end
        $display("wake rows done");
        wb(CTRL_OFS, 1'b1, 32'h0000000d);
        wb(IRQEN_OFS, 1'b1, 32'h00000001);
        wb(IRQCTL_OFS, 1'b1, 32'h00000080);
        sleepNow();
        chk(32'({cpuClkEn, periphClkEn, clkSrc, primaryOscEn, intRcEn}), 32'h19, "idle clocks");
        wb(STATUS_OFS, 1'b0, 32'h0);
        chk(q & 32'h1d, 32'h08, "idle status");
        reqFlags <= 8'h02;
        repeat (20) @(posedge ref_clk);
        chk(32'(cpuClkEn), 32'h0, "masked flag");
        sawBr <= 1'b0;
        reqFlags <= 8'h03;
        waitCpu();
        reqFlags <= 8'h00;
        @(posedge ref_clk);
        chkIn(n, CSD + 3, CSD + 3, "idle exit");
        chk(32'({drop, clkSrc, sawBr}), 32'h5, "idle wake");
        wb(CTRL_OFS, 1'b0, 32'h0);
        chk(q, 32'h0000000d, "select kept");
        $display("idle test done");
        wb(CTRL_OFS, 1'b1, 32'h00000004);
        sleepNow();
        chk(32'(periphClkEn), 32'h0, "sleep entry");
        sawBr <= 1'b0;
        reqWdt <= 1'b1;
        @(posedge ref_clk);
        reqWdt <= 1'b0;
        waitCpu();
        chkIn(n, CSD + 1, 60, "watchdog wake");
        chk(32'(intRcSettling), 32'h1, "settling after sleep");
        chk(32'({clkSrc, sawWdt, sawBr}), 32'h8, "watchdog wake");
        reqWdt <= 1'b1;
        @(posedge ref_clk);
        reqWdt <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk(32'(sawWdt), 32'h1, "watchdog in run");
        $display("watchdog test done");
        ceIn <= 1'b0;
        sleepNow();
        ceIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(32'({cpuClkEn, periphClkEn}), 32'h3, "frozen sleep ignored");
        $display("clock enable test done");
        doReset();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        complete_run();
    end
endmodule
